// *** vpw_pkg.sv ***
// package for the video capture/playback window register bank
// assumes an 8-bit indexed port: index written at one address, data at another
package vpw_pkg;
    localparam logic [7:0] IDX_CAP_LEFT_LO   = 8'h0e;
    localparam logic [7:0] IDX_CAP_LEFT_HI   = 8'h0f;
    localparam logic [7:0] IDX_CAP_RIGHT_LO  = 8'h10;
    localparam logic [7:0] IDX_CAP_RIGHT_HI  = 8'h11;
    localparam logic [7:0] IDX_CAP_TOP_LO    = 8'h12;
    localparam logic [7:0] IDX_CAP_TOP_HI    = 8'h13;
    localparam logic [7:0] IDX_CAP_BOT_LO    = 8'h14;
    localparam logic [7:0] IDX_CAP_BOT_HI    = 8'h15;
    localparam logic [7:0] IDX_CAP_HSCALE    = 8'h16;
    localparam logic [7:0] IDX_CAP_VSCALE    = 8'h17;
    localparam logic [7:0] IDX_CAP_INTERVAL  = 8'h18;
    localparam logic [7:0] IDX_PB_CTRL_A     = 8'h1e;
    localparam logic [7:0] IDX_PB_CTRL_B     = 8'h1f;
    localparam logic [7:0] IDX_PB_BUF_CTRL   = 8'h20;
    localparam logic [7:0] IDX_PB_BUF_STAT   = 8'h21;
    localparam logic [7:0] IDX_PB_PTR_A0     = 8'h22;
    localparam logic [7:0] IDX_PB_PTR_B0     = 8'h25;
    localparam logic [7:0] IDX_PB_SPAN       = 8'h28;
    localparam logic [7:0] IDX_PB_LEFT_LO    = 8'h2a;
    localparam logic [7:0] IDX_PB_LEFT_HI    = 8'h2b;
    localparam logic [7:0] IDX_PB_RIGHT_LO   = 8'h2c;
    localparam logic [7:0] IDX_PB_RIGHT_HI   = 8'h2d;
    localparam logic [7:0] IDX_PB_TOP_LO     = 8'h2e;
    localparam logic [7:0] IDX_PB_TOP_HI     = 8'h2f;
    localparam logic [7:0] IDX_PB_BOT_LO     = 8'h30;
    localparam logic [7:0] IDX_PB_BOT_HI     = 8'h31;
    // field positions
    localparam int CA_INTERLACE = 4;
    localparam int CA_VERTICAL_MAGNIFY_FACTOR     = 3;
    localparam int CA_HORIZONTAL_MAGNIFY_FACTOR     = 2;
    localparam int CA_YFLIP     = 1;
    localparam int CA_XMIRROR   = 0;
    localparam int CB_VINT_EN   = 7;
    localparam int CB_VINT_AVG  = 6;
    localparam int CB_HINT_EN   = 5;
    localparam int CB_RGB       = 3;
    localparam int CB_SIGNED    = 1;
    localparam int CB_TYPE      = 0;
    localparam int BC_VLOCK     = 5;
    localparam int BC_FLAG      = 4;
    localparam int BC_SOURCE    = 3;
    localparam int BC_TRIGGER   = 2;
    localparam int BS_IN_USE    = 1;
    localparam int BS_PENDING   = 0;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] HI_MASK   = 8'h07;
    localparam logic [7:0] PTR0_MASK = 8'hf8;
    localparam logic [7:0] CA_MASK   = 8'h1f;
    localparam logic [7:0] CB_MASK   = 8'heb;
    localparam logic [7:0] BC_MASK   = 8'h3c;
    localparam int NREG = 8'd50;
    typedef struct packed {
        logic [3:0] fmt;
        logic       interlace;
        logic       vertical_magnify_factor;
        logic       horizontal_magnify_factor;
        logic       yflip;
        logic       xmirror;
        logic       vint_en;
        logic       vint_avg;
        logic       hint_en;
    } vpw_mode_t;
    typedef enum logic [3:0] {
        FMT_YUV, FMT_YVU, FMT_YUV_S, FMT_YVU_S, FMT_RGB565, FMT_RGB555
    } vpw_fmt_e_t;
endpackage

// *** vpw_regs.sv ***
// video capture / playback window register bank
// assumes index/data writes are single-cycle strobes synchronous to CORE_CLK
//
// Function
// R01 - capture edges: low byte plus three bits
// R02 - software keeps capture window within 1024x1024
// R03 - eight-bit capture interval register
// R04 - interlace, vertical and horizontal zoom enables
// R05 - vertical flip and horizontal mirror bits
// R06 - vertical interpolation enable and method
// R07 - horizontal interpolation enable
// R08 - YUV 4:2:2 with swap and sign
// R09 - RGB 565 or 555, blue low
// R10 - sign bit: offset or two's complement
// R11 - buffer switch free or vsync locked
// R12 - software flag picks first or second pointer
// R13 - buffer source: flag or last capture
// R14 - trigger adopts new pointer at vsync
// R15 - status: pointer in use, pending
// R16 - pointers 24 bits, low three zero
// R17 - eight-bit line span register
// R18 - playback left edge, eleven bits, reset zero
// R19 - playback right low byte, reset zero
// R20 - right edge upper three bits
// R21 - top and bottom edges, eleven bits
// R22 - capture every n-th frame when enabled
// R23 - capture reports last buffer grabbed
// R24 - video only inside window, inclusive edges
// R25 - scale factors n/256 when enabled
`timescale 1ns/1ps
module vpw_regs
    import vpw_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        IDX_WR,
    input  wire logic        DATA_WR,
    input  wire logic        DATA_RD,
    input  wire logic [7:0]  WDATA,
    input  wire logic        VSYNC_PIN,
    input  wire logic        CAP_FIELD_DONE,
    input  wire logic        CAP_COUNT_EN,
    input  wire logic        CAP_LAST_BUF,
    input  wire logic        HSCALE_EN,
    input  wire logic        VSCALE_EN,
    input  wire logic [10:0] RASTER_X,
    input  wire logic [10:0] RASTER_Y,
    input  wire logic [7:0]  HSRC_COUNT,
    input  wire logic [7:0]  VSRC_COUNT,
    output logic      [7:0]  RDATA,
    output logic      [23:0] PB_POINTER,
    output logic      [7:0]  PB_SPAN,
    output vpw_mode_t        PB_MODE,
    output logic             PB_IN_WINDOW,
    output logic             CAP_GRAB,
    output logic             CAP_LAST_BUF_OUT,
    output logic      [7:0]  HSCALE_OUT,
    output logic      [7:0]  VSCALE_OUT
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]  index;
        logic [NREG*8-1:0] regs;
        logic        in_use;
        logic        pending;
        logic [2:0]  vs_sync;
        logic        vs_prev;
        logic [7:0]  frame_cnt;
        logic        grab;
        logic        last_buf;
        logic [7:0]  rdata;
        logic [23:0] ptr;
        logic [7:0]  span;
        vpw_mode_t   mode;
        logic        in_win;
        logic [7:0]  hscale;
        logic [7:0]  vscale;
    } vpw_state_t;

    vpw_state_t st_reg;
    vpw_state_t st_next;

    function automatic logic [7:0] rbyte(input logic [NREG*8-1:0] r, input logic [7:0] i);
        rbyte = r[i*8 +: 8];
    endfunction

    function automatic logic [10:0] edge11(input logic [NREG*8-1:0] r, input logic [7:0] lo);
        logic [7:0] h;
        h = rbyte(r, lo + 8'd1);
        edge11 = {h[2:0], rbyte(r, lo)};
    endfunction

    function automatic logic [7:0] wmask(input logic [7:0] i);
        unique case (i)
            IDX_CAP_LEFT_HI, IDX_CAP_RIGHT_HI, IDX_CAP_TOP_HI, IDX_CAP_BOT_HI,
            IDX_PB_LEFT_HI, IDX_PB_RIGHT_HI, IDX_PB_TOP_HI, IDX_PB_BOT_HI:
                wmask = HI_MASK; // R01 R18 R20 R21
            IDX_CAP_LEFT_LO, IDX_CAP_RIGHT_LO, IDX_CAP_TOP_LO, IDX_CAP_BOT_LO,
            IDX_CAP_HSCALE, IDX_CAP_VSCALE, IDX_CAP_INTERVAL, IDX_PB_SPAN,
            IDX_PB_LEFT_LO, IDX_PB_RIGHT_LO, IDX_PB_TOP_LO, IDX_PB_BOT_LO,
            8'h23, 8'h24, 8'h26, 8'h27:
                wmask = 8'hff; // R03 R17 R19
            IDX_PB_PTR_A0, IDX_PB_PTR_B0: wmask = PTR0_MASK; // R16
            IDX_PB_CTRL_A:   wmask = CA_MASK;
            IDX_PB_CTRL_B:   wmask = CB_MASK;
            IDX_PB_BUF_CTRL: wmask = BC_MASK;
            default:         wmask = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  ca;
    logic [7:0]  cb;
    logic [7:0]  bc;
    logic        vs_rise;
    logic        want_buf;
    logic [10:0] xl;
    logic [10:0] xr;
    logic [10:0] yt;
    logic [10:0] yb;

    always_comb begin
        st_next = st_reg;
        ca = rbyte(st_reg.regs, IDX_PB_CTRL_A);
        cb = rbyte(st_reg.regs, IDX_PB_CTRL_B);
        bc = rbyte(st_reg.regs, IDX_PB_BUF_CTRL);
        xl = edge11(st_reg.regs, IDX_PB_LEFT_LO);
        xr = edge11(st_reg.regs, IDX_PB_RIGHT_LO);
        yt = edge11(st_reg.regs, IDX_PB_TOP_LO);
        yb = edge11(st_reg.regs, IDX_PB_BOT_LO);
        // vsync filtered: change counts once stages two and three agree
        st_next.vs_sync = {st_reg.vs_sync[1:0], VSYNC_PIN};
        if (st_reg.vs_sync[2] == st_reg.vs_sync[1]) begin
            st_next.vs_prev = st_reg.vs_sync[2];
        end
        vs_rise = (st_reg.vs_sync[2] == st_reg.vs_sync[1]) && st_reg.vs_sync[2] && !st_reg.vs_prev;
        // register writes
        if (IDX_WR) begin
            st_next.index = WDATA;
        end
        if (DATA_WR && st_reg.index < 8'(NREG)) begin
            st_next.regs[st_reg.index*8 +: 8] = WDATA & wmask(st_reg.index);
        end
        // buffer selection
        want_buf = bc[BC_SOURCE] ? st_reg.last_buf : bc[BC_FLAG]; // R12 R13
        if (!bc[BC_VLOCK]) begin
            st_next.in_use  = want_buf; // R11
            st_next.pending = 1'b0;
        end else if (bc[BC_TRIGGER]) begin
            st_next.pending = 1'b1; // R14
            if (vs_rise) begin
                st_next.in_use  = want_buf; // R14
                st_next.pending = 1'b0;
                st_next.regs[IDX_PB_BUF_CTRL*8 + BC_TRIGGER] = 1'b0;
            end
        end else begin
            st_next.pending = 1'b0; // R14
        end
        // capture interval
        st_next.grab = 1'b0;
        st_next.last_buf = CAP_LAST_BUF; // R23
        if (CAP_FIELD_DONE) begin
            if (!CAP_COUNT_EN) begin
                st_next.grab = 1'b1;
            end else if (st_reg.frame_cnt + 8'd1 >= rbyte(st_reg.regs, IDX_CAP_INTERVAL)) begin
                st_next.grab      = 1'b1; // R22
                st_next.frame_cnt = 8'h00;
            end else begin
                st_next.frame_cnt = st_reg.frame_cnt + 8'd1;
            end
        end
        // read data
        if (st_reg.index == IDX_PB_BUF_STAT) begin
            st_next.rdata = {6'h00, st_reg.in_use, st_reg.pending}; // R15
        end else if (st_reg.index < 8'(NREG)) begin
            st_next.rdata = rbyte(st_reg.regs, st_reg.index);
        end else begin
            st_next.rdata = 8'h00;
        end
        // outputs
        st_next.ptr = st_reg.in_use
            ? {rbyte(st_reg.regs, IDX_PB_PTR_B0 + 8'd2), rbyte(st_reg.regs, IDX_PB_PTR_B0 + 8'd1),
               rbyte(st_reg.regs, IDX_PB_PTR_B0)}
            : {rbyte(st_reg.regs, IDX_PB_PTR_A0 + 8'd2), rbyte(st_reg.regs, IDX_PB_PTR_A0 + 8'd1),
               rbyte(st_reg.regs, IDX_PB_PTR_A0)}; // R16
        st_next.span = rbyte(st_reg.regs, IDX_PB_SPAN); // R17
        st_next.mode.interlace = ca[CA_INTERLACE]; // R04
        st_next.mode.vertical_magnify_factor     = ca[CA_VERTICAL_MAGNIFY_FACTOR];
        st_next.mode.horizontal_magnify_factor     = ca[CA_HORIZONTAL_MAGNIFY_FACTOR];
        st_next.mode.yflip     = ca[CA_YFLIP]; // R05
        st_next.mode.xmirror   = ca[CA_XMIRROR];
        st_next.mode.vint_en   = cb[CB_VINT_EN]; // R06
        st_next.mode.vint_avg  = cb[CB_VINT_EN] & cb[CB_VINT_AVG];
        st_next.mode.hint_en   = cb[CB_HINT_EN]; // R07
        if (cb[CB_RGB]) begin
            st_next.mode.fmt = cb[CB_TYPE] ? FMT_RGB555 : FMT_RGB565; // R09
        end else begin
            st_next.mode.fmt = {2'b00, cb[CB_SIGNED], cb[CB_TYPE]}; // R08 R10
        end
        st_next.in_win = (RASTER_X >= xl) && (RASTER_X <= xr) && (RASTER_Y >= yt) && (RASTER_Y <= yb); // R24
        st_next.hscale = HSCALE_EN ? 8'(({8'h00, HSRC_COUNT} * {8'h00, rbyte(st_reg.regs, IDX_CAP_HSCALE)}) >> 8)
                                   : HSRC_COUNT; // R25
        st_next.vscale = VSCALE_EN ? 8'(({8'h00, VSRC_COUNT} * {8'h00, rbyte(st_reg.regs, IDX_CAP_VSCALE)}) >> 8)
                                   : VSRC_COUNT;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA            = st_reg.rdata;
    assign PB_POINTER       = st_reg.ptr;
    assign PB_SPAN          = st_reg.span;
    assign PB_MODE          = st_reg.mode;
    assign PB_IN_WINDOW     = st_reg.in_win;
    assign CAP_GRAB         = st_reg.grab;
    assign CAP_LAST_BUF_OUT = st_reg.last_buf;
    assign HSCALE_OUT       = st_reg.hscale;
    assign VSCALE_OUT       = st_reg.vscale;

    ////////////////////////////////////////////////////////////////////////
    ptr_align_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        PB_POINTER[2:0] == 3'b000) else $error("pointer not aligned"); // R16
    hi_reserved_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DATA_WR && st_reg.index == IDX_PB_LEFT_HI |=> st_reg.regs[IDX_PB_LEFT_HI*8+3 +: 5] == 5'h00)
        else $error("reserved bits stored"); // R18
    cap_hi_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        DATA_WR && st_reg.index == IDX_CAP_LEFT_HI |=> st_reg.regs[IDX_CAP_LEFT_HI*8 +: 3] == $past(WDATA[2:0]))
        else $error("capture edge high wrong"); // R01
    free_run_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !bc[BC_VLOCK] && !bc[BC_SOURCE] |=> st_reg.in_use == $past(bc[BC_FLAG]))
        else $error("free-run select wrong"); // R11
    hold_ptr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        bc[BC_VLOCK] && !bc[BC_TRIGGER] |=> $stable(st_reg.in_use)) else $error("pointer changed"); // R14
    pend_stat_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        bc[BC_VLOCK] && bc[BC_TRIGGER] && !vs_rise |=> st_reg.pending) else $error("pending missing"); // R15
    win_out_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        RASTER_X < xl |=> !PB_IN_WINDOW) else $error("outside window"); // R24
    fmt_rgb_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        cb[CB_RGB] && !cb[CB_TYPE] |=> PB_MODE.fmt == FMT_RGB565) else $error("rgb format wrong"); // R09
    vint_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !cb[CB_VINT_EN] |=> !PB_MODE.vint_avg) else $error("avg without enable"); // R06
    grab_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CAP_FIELD_DONE && !CAP_COUNT_EN |=> CAP_GRAB) else $error("grab missing"); // R22

endmodule

// *** vpw_regs_tb.sv ***
// self-checking bench for the capture/playback window register bank
// assumes vpw_regs registers every output on CORE_CLK and resets synchronously on RST_N low
`timescale 1ns/1ps
module vpw_regs_tb
    import vpw_pkg::*;
;
    typedef struct {
        string       nm;
        int          sel;
        logic [23:0] val;
    } vpw_chk_t;
    logic        CORE_CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        IDX_WR = 1'b0;
    logic        DATA_WR = 1'b0;
    logic [7:0]  WDATA = 8'h00;
    logic        VSYNC_PIN = 1'b0;
    logic        CAP_FIELD_DONE = 1'b0;
    logic        CAP_COUNT_EN = 1'b0;
    logic        CAP_LAST_BUF = 1'b0;
    logic        HSCALE_EN = 1'b0;
    logic        VSCALE_EN = 1'b0;
    logic [10:0] RASTER_X = 11'h000;
    logic [10:0] RASTER_Y = 11'h000;
    logic [7:0]  HSRC_COUNT = 8'h00;
    logic [7:0]  VSRC_COUNT = 8'h00;
    logic [7:0]  RDATA, PB_SPAN, HSCALE_OUT, VSCALE_OUT;
    logic [23:0] PB_POINTER, seen;
    vpw_mode_t   PB_MODE;
    logic        PB_IN_WINDOW, CAP_GRAB, CAP_LAST_BUF_OUT;
    vpw_chk_t    q[$];
    vpw_chk_t    c;
    event        chk_ev;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          grab_cnt = 0;
    logic [31:0] lfsr_st = 32'h4bc8;
    logic [7:0]  d, a;
    logic [10:0] xs[4] = '{11'h001, 11'h002, 11'h105, 11'h106};
    logic [10:0] ys[4] = '{11'h102, 11'h103, 11'h104, 11'h105};

    vpw_regs vpw_regs_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .IDX_WR(IDX_WR), .DATA_WR(DATA_WR),
        .DATA_RD(1'b0), .WDATA(WDATA), .VSYNC_PIN(VSYNC_PIN), .CAP_FIELD_DONE(CAP_FIELD_DONE),
        .CAP_COUNT_EN(CAP_COUNT_EN), .CAP_LAST_BUF(CAP_LAST_BUF), .HSCALE_EN(HSCALE_EN),
        .VSCALE_EN(VSCALE_EN), .RASTER_X(RASTER_X), .RASTER_Y(RASTER_Y), .HSRC_COUNT(HSRC_COUNT),
        .VSRC_COUNT(VSRC_COUNT), .RDATA(RDATA), .PB_POINTER(PB_POINTER), .PB_SPAN(PB_SPAN),
        .PB_MODE(PB_MODE), .PB_IN_WINDOW(PB_IN_WINDOW), .CAP_GRAB(CAP_GRAB),
        .CAP_LAST_BUF_OUT(CAP_LAST_BUF_OUT), .HSCALE_OUT(HSCALE_OUT), .VSCALE_OUT(VSCALE_OUT));

    always #2.5 CORE_CLK = ~CORE_CLK;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        lfsr_st = {1'b0, lfsr_st[31:1]} ^ (lfsr_st[0] ? 32'h80200003 : 32'h0);
        return lfsr_st[7:0];
    endfunction
    function automatic logic [7:0] wmask(input logic [7:0] idx);
        if (idx inside {8'h0f, 8'h11, 8'h13, 8'h15, 8'h2b, 8'h2d, 8'h2f, 8'h31}) return 8'h07;
        if (idx inside {8'h22, 8'h25}) return 8'hf8;
        if (idx == 8'h1e) return 8'h1f;
        if (idx == 8'h1f) return 8'heb;
        return 8'hff;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    task automatic put(input logic [7:0] idx, input logic [7:0] v);
        @(posedge CORE_CLK);
        IDX_WR <= 1'b1;
        WDATA  <= idx;
        @(posedge CORE_CLK);
        IDX_WR  <= 1'b0;
        DATA_WR <= 1'b1;
        WDATA   <= v;
        @(posedge CORE_CLK);
        DATA_WR <= 1'b0;
    endtask
    // notes the expected value once the output has settled and wakes the monitor
    task automatic expect_out(input string nm, input int sel, input logic [23:0] v);
        tick(3);
        @(negedge CORE_CLK);
        q.push_back('{nm, sel, v});
        -> chk_ev;
        @(posedge CORE_CLK);
    endtask
    task automatic get(input logic [7:0] idx, input logic [7:0] v);
        @(posedge CORE_CLK);
        IDX_WR <= 1'b1;
        WDATA  <= idx;
        @(posedge CORE_CLK);
        IDX_WR <= 1'b0;
        expect_out("RDATA", 0, {16'h0, v});
    endtask
    task automatic vsync();
        VSYNC_PIN <= 1'b1;
        tick(6);
        VSYNC_PIN <= 1'b0;
        tick(6);
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge CORE_CLK) begin
        if (CAP_GRAB === 1'b1) grab_cnt <= grab_cnt + 1;
    end
    always @(chk_ev) begin
        while (q.size() > 0) begin
            c = q.pop_front();
            case (c.sel)
                0: seen = {16'h0, RDATA};
                1: seen = PB_POINTER;
                2: seen = {12'h0, PB_MODE};
                3: seen = {23'h0, PB_IN_WINDOW};
                4: seen = {8'h0, HSCALE_OUT, VSCALE_OUT};
                5: seen = {16'h0, PB_SPAN};
                6: seen = {23'h0, CAP_LAST_BUF_OUT};
                default: seen = grab_cnt[23:0];
            endcase
            n_compared++;
            if (seen !== c.val) begin
                error_cnt++;
                $display("mismatch %s expected %h seen %h", c.nm, c.val, seen);
            end
        end
    end
    initial begin
        #(20000 * 5);
        error_cnt++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        RST_N <= 1'b1;
        for (int i = 8'h1e; i <= 8'h31; i++) begin
            if (i inside {[8'h1e:8'h21], [8'h2a:8'h31]}) get(i[7:0], 8'h00);
        end
        expect_out("PB_POINTER", 1, 24'h0);
        $display("test reset done");
        for (int i = 8'h0e; i <= 8'h31; i++) begin
            if (!(i inside {[8'h19:8'h1d], 8'h20, 8'h21, 8'h29})) begin
                d = rnd();
                if (i inside {8'h0f, 8'h11, 8'h13, 8'h15}) d = d & 8'h03;
                put(i[7:0], d);
                get(i[7:0], d & wmask(i[7:0]));
            end
        end
        put(IDX_PB_BUF_STAT, 8'hff);
        get(IDX_PB_BUF_STAT, 8'h00);
        put(8'h40, 8'h5a);
        get(8'h40, 8'h00);
        $display("test register access done");
        for (int i = 0; i < 8; i++) begin
            a = rnd() & 8'h1f;
            d = rnd();
            put(IDX_PB_CTRL_A, a);
            put(IDX_PB_CTRL_B, {d[7], d[6], d[5], 1'b0, i[2], 1'b0, i[1:0]});
            expect_out("PB_MODE", 2, {12'h0, (i[2] ? (i[0] ? 4'd5 : 4'd4) : {2'b0, i[1:0]}),
                       a[4:0], d[7], d[7] & d[6], d[5]});
        end
        $display("test mode done");
        for (int k = 0; k < 3; k++) begin
            put(IDX_PB_PTR_A0 + 8'(k), 8'({24'h123457} >> (8 * k)));
            put(IDX_PB_PTR_B0 + 8'(k), 8'({24'habcdff} >> (8 * k)));
        end
        put(IDX_PB_BUF_CTRL, 8'h00);
        expect_out("PB_POINTER", 1, 24'h123450);
        put(IDX_PB_BUF_CTRL, 8'h10);
        expect_out("PB_POINTER", 1, 24'habcdf8);
        put(IDX_PB_BUF_CTRL, 8'h24);
        expect_out("PB_POINTER", 1, 24'habcdf8);
        get(IDX_PB_BUF_STAT, 8'h03);
        vsync();
        expect_out("PB_POINTER", 1, 24'h123450);
        get(IDX_PB_BUF_STAT, 8'h00);
        get(IDX_PB_BUF_CTRL, 8'h20);
        put(IDX_PB_BUF_CTRL, 8'h30);
        vsync();
        expect_out("PB_POINTER", 1, 24'h123450);
        CAP_LAST_BUF <= 1'b1;
        put(IDX_PB_BUF_CTRL, 8'h08);
        expect_out("PB_POINTER", 1, 24'habcdf8);
        expect_out("CAP_LAST_BUF_OUT", 6, 24'h1);
        CAP_LAST_BUF <= 1'b0;
        expect_out("PB_POINTER", 1, 24'h123450);
        $display("test buffer done");
        put(8'h2a, 8'h02);
        put(8'h2b, 8'h00);
        put(8'h2c, 8'h05);
        put(8'h2d, 8'h01);
        put(8'h2e, 8'h03);
        put(8'h2f, 8'h01);
        put(8'h30, 8'h04);
        put(8'h31, 8'h01);
        foreach (xs[i]) begin
            foreach (ys[j]) begin
                RASTER_X <= xs[i];
                RASTER_Y <= ys[j];
                expect_out("PB_IN_WINDOW", 3, {23'h0, i inside {1, 2} && j inside {1, 2}});
            end
        end
        $display("test window done");
        CAP_COUNT_EN <= 1'b1;
        for (int n = 1; n <= 3; n += 2) begin
            put(IDX_CAP_INTERVAL, 8'(n));
            tick(2);
            grab_cnt = 0;
            repeat (6) begin
                CAP_FIELD_DONE <= 1'b1;
                tick(1);
                CAP_FIELD_DONE <= 1'b0;
                tick(3);
            end
            expect_out("CAP_GRAB count", 7, 24'(6 / n));
        end
        $display("test interval done");
        put(IDX_CAP_HSCALE, 8'h80);
        put(IDX_CAP_VSCALE, 8'h40);
        put(IDX_PB_SPAN, 8'h50);
        HSCALE_EN  <= 1'b1;
        HSRC_COUNT <= 8'd200;
        VSRC_COUNT <= 8'd77;
        expect_out("SCALE_OUT", 4, {8'h0, 8'd100, 8'd77});
        VSCALE_EN <= 1'b1;
        expect_out("SCALE_OUT", 4, {8'h0, 8'd100, 8'd19});
        expect_out("PB_SPAN", 5, 24'h50);
        $display("test scale done");
        tick(2);
        end_sim();
    end
endmodule
